/* File: verilog/stream_entry_pkg.sv */
package stream_entry_pkg;

    // Entry geometry
    localparam int ENTRY_BYTES = 64;
    localparam int ENTRY_BITS  = ENTRY_BYTES * 8;
    localparam int ENTRY_SHIFT = 6;

    // Entry field positions (bit offsets inside the 512-bit entry)
    localparam int VALID_BIT  = 0;
    localparam int CFG_LSB    = 1;
    localparam int CFG_W      = 3;
    localparam int FMT_LSB    = 4;
    localparam int FMT_W      = 2;
    localparam int CTX_LSB    = 6;
    localparam int CTX_W      = 46;
    localparam int CDMAX_LSB  = 59;
    localparam int CDMAX_W    = 5;
    localparam int VMID_LSB   = 128;
    localparam int VMID_W     = 16;
    localparam int GRAN_LSB   = 166;
    localparam int IR_LSB     = 168;
    localparam int OR_LSB     = 170;
    localparam int SH_LSB     = 172;
    localparam int ATTR_W     = 2;
    localparam int PS_LSB     = 176;
    localparam int PS_W       = 3;
    localparam int AA64_BIT   = 179;
    localparam int ENDI_BIT   = 180;
    localparam int AFFD_BIT   = 181;
    localparam int TTB_LSB    = 196;
    localparam int TTB_W      = 48;

    // Translation configuration codes
    localparam logic [CFG_W-1:0] CFG_ABORT  = 3'h0;
    localparam logic [CFG_W-1:0] CFG_BYPASS = 3'h4;
    localparam logic [CFG_W-1:0] CFG_S1     = 3'h5;
    localparam logic [CFG_W-1:0] CFG_S2     = 3'h6;
    localparam logic [CFG_W-1:0] CFG_S12    = 3'h7;

    // Reset value of the enable acknowledge
    localparam logic ACK_RESET = 1'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_FETCH = 2'h1
    } state_e;

endpackage

/* File: verilog/entry_field_decode.sv */
`timescale 1ns/1ps
module entry_field_decode
(
    // Raw entry
    input  wire logic [stream_entry_pkg::ENTRY_BITS-1:0] entry,
    // Classification
    output logic                                         abort,
    output logic                                         stage1_on,
    output logic                                         stage2_on,
    output logic [stream_entry_pkg::CFG_W-1:0]           config_code,
    // Fields
    output logic [stream_entry_pkg::CDMAX_W-1:0]         count_limit,
    output logic [stream_entry_pkg::FMT_W-1:0]           table_format,
    output logic [stream_entry_pkg::CTX_W-1:0]           context_pointer,
    output logic [stream_entry_pkg::TTB_W-1:0]           table_base,
    output logic [stream_entry_pkg::PS_W-1:0]            physical_size,
    output logic                                         format64,
    output logic                                         big_endian,
    output logic                                         affd,
    output logic [stream_entry_pkg::ATTR_W-1:0]          granule,
    output logic [stream_entry_pkg::ATTR_W-1:0]          inner_cache,
    output logic [stream_entry_pkg::ATTR_W-1:0]          outer_cache,
    output logic [stream_entry_pkg::ATTR_W-1:0]          shareability,
    output logic [stream_entry_pkg::VMID_W-1:0]          vmid
);

    logic entry_valid;
    logic known_code;

    assign entry_valid = entry[stream_entry_pkg::VALID_BIT];
    assign config_code = entry[stream_entry_pkg::CFG_LSB +: stream_entry_pkg::CFG_W];

    // Any code with the top bit clear other than the abort code is unusable
    assign known_code = config_code[stream_entry_pkg::CFG_W-1];                  // [RULE19]
    assign abort      = !entry_valid || !known_code;                              // [RULE3] [RULE18] [RULE19]
    assign stage1_on  = !abort && config_code[0];                                 // [RULE5] [RULE7]
    assign stage2_on  = !abort && config_code[1];                                 // [RULE6] [RULE7]

    assign count_limit     = entry[stream_entry_pkg::CDMAX_LSB +: stream_entry_pkg::CDMAX_W];
    assign table_format    = entry[stream_entry_pkg::FMT_LSB +: stream_entry_pkg::FMT_W];
    assign context_pointer = entry[stream_entry_pkg::CTX_LSB +: stream_entry_pkg::CTX_W];
    assign table_base      = entry[stream_entry_pkg::TTB_LSB +: stream_entry_pkg::TTB_W];
    assign physical_size   = entry[stream_entry_pkg::PS_LSB +: stream_entry_pkg::PS_W];
    assign format64        = entry[stream_entry_pkg::AA64_BIT];
    assign big_endian      = entry[stream_entry_pkg::ENDI_BIT];
    assign affd            = entry[stream_entry_pkg::AFFD_BIT];
    assign granule         = entry[stream_entry_pkg::GRAN_LSB +: stream_entry_pkg::ATTR_W];
    assign inner_cache     = entry[stream_entry_pkg::IR_LSB +: stream_entry_pkg::ATTR_W];
    assign outer_cache     = entry[stream_entry_pkg::OR_LSB +: stream_entry_pkg::ATTR_W];
    assign shareability    = entry[stream_entry_pkg::SH_LSB +: stream_entry_pkg::ATTR_W];
    assign vmid            = entry[stream_entry_pkg::VMID_LSB +: stream_entry_pkg::VMID_W];

endmodule

/* File: verilog/stream_entry_decode_enable.sv */
// Operation
// RULE1: Each accepted transaction fetches exactly one entry, indexed by its stream identifier.
// RULE2: Entries are 64 bytes; entry address is table base plus identifier times 64.
// RULE3: Configuration code zero aborts the transaction; nothing passes.
// RULE4: Code 100 bypasses both stages and forwards the address unchanged.
// RULE5: Code 101 enables first-stage translation only.
// RULE6: Code 110 enables second-stage translation only.
// RULE7: Code 111 enables first stage followed by second stage.
// RULE8: Descriptor count limit selects single descriptor versus descriptor table.
// RULE9: Descriptor table format is used only when the count limit exceeds zero.
// RULE10: Context pointer is an intermediate address when second stage is on.
// RULE11: Second-stage walks start at the entry's table base.
// RULE12: Physical size bounds second-stage output; format field picks 32/64-bit tables.
// RULE13: Second-stage tables are read in the entry's byte order.
// RULE14: Access flag fault disable suppresses those faults in second stage.
// RULE15: Second-stage results carry the entry's virtual machine identifier.
// RULE16: Software writes all entries before setting the translation enable bit.
// RULE17: Acknowledge bit mirrors the enable bit once it takes effect.
// RULE18: An entry with valid bit clear is never used as a translation setup.
// RULE19: Unlisted configuration codes are treated as invalid and abort.
// RULE20: While the acknowledge reads zero, entries are not applied. Code still applies an entry whose fetch starts as it drops.
`timescale 1ns/1ps
module stream_entry_decode_enable
#(
    parameter int SID_W  = 16,
    parameter int ADDR_W = 52
)
(
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    resetn,
    // Global enable handshake
    input  wire logic                                    translation_enable_bit,
    output logic                                         translation_enable_ack,
    // Stream table location
    input  wire logic [ADDR_W-1:0]                       stream_table_base,
    // Transaction request
    input  wire logic                                    req_valid,
    output logic                                         req_ready,
    input  wire logic [SID_W-1:0]                        req_stream_id,
    input  wire logic [ADDR_W-1:0]                       req_addr,
    // Entry fetch
    output logic                                         entry_req_valid,
    output logic [ADDR_W-1:0]                            entry_req_addr,
    input  wire logic                                    entry_rsp_valid,
    input  wire logic [stream_entry_pkg::ENTRY_BITS-1:0] entry_rsp_data,
    // Decision
    output logic                                         rsp_valid,
    output logic                                         rsp_abort,
    output logic                                         rsp_bypass,
    output logic                                         rsp_entry_used,
    output logic [ADDR_W-1:0]                            rsp_addr,
    output logic [stream_entry_pkg::CFG_W-1:0]           rsp_config,
    output logic                                         stage1_enable,
    output logic                                         stage2_enable,
    // First-stage context
    output logic                                         descriptor_single,
    output logic [stream_entry_pkg::CDMAX_W-1:0]         descriptor_count_limit,
    output logic [stream_entry_pkg::FMT_W-1:0]           descriptor_table_format,
    output logic [stream_entry_pkg::CTX_W-1:0]           first_stage_context_pointer,
    output logic                                         context_pointer_is_ipa,
    // Second-stage walk setup
    output logic [stream_entry_pkg::TTB_W-1:0]           second_stage_table_base,
    output logic [stream_entry_pkg::PS_W-1:0]            second_stage_physical_size,
    output logic                                         second_stage_table_format,
    output logic                                         second_stage_endianness,
    output logic                                         access_flag_fault_disable,
    output logic [stream_entry_pkg::ATTR_W-1:0]          second_stage_granule,
    output logic [stream_entry_pkg::ATTR_W-1:0]          second_stage_inner_cacheability,
    output logic [stream_entry_pkg::ATTR_W-1:0]          second_stage_outer_cacheability,
    output logic [stream_entry_pkg::ATTR_W-1:0]          second_stage_shareability,
    output logic [stream_entry_pkg::VMID_W-1:0]          virtual_machine_identifier
);

    stream_entry_pkg::state_e state_reg;
    logic [ADDR_W-1:0]        addr_reg;
    logic [SID_W-1:0]         sid_reg;
    logic                     taken;
    logic                     start_fetch;
    logic                     entry_done;

    logic                                  d_abort;
    logic                                  d_s1;
    logic                                  d_s2;
    logic [stream_entry_pkg::CFG_W-1:0]    d_cfg;
    logic [stream_entry_pkg::CDMAX_W-1:0]  d_limit;
    logic [stream_entry_pkg::FMT_W-1:0]    d_fmt;
    logic [stream_entry_pkg::CTX_W-1:0]    d_ctx;
    logic [stream_entry_pkg::TTB_W-1:0]    d_ttb;
    logic [stream_entry_pkg::PS_W-1:0]     d_ps;
    logic                                  d_aa64;
    logic                                  d_endi;
    logic                                  d_affd;
    logic [stream_entry_pkg::ATTR_W-1:0]   d_gran;
    logic [stream_entry_pkg::ATTR_W-1:0]   d_ir;
    logic [stream_entry_pkg::ATTR_W-1:0]   d_or;
    logic [stream_entry_pkg::ATTR_W-1:0]   d_sh;
    logic [stream_entry_pkg::VMID_W-1:0]   d_vmid;

    assign taken       = req_valid && req_ready;
    // Entries are only consulted once the enable has been acknowledged
    assign start_fetch = taken && translation_enable_ack;                         // [RULE20]
    assign entry_done  = (state_reg == stream_entry_pkg::ST_FETCH) && entry_rsp_valid;

    entry_field_decode u_decode
    (
        .entry           (entry_rsp_data),
        .abort           (d_abort),
        .stage1_on       (d_s1),
        .stage2_on       (d_s2),
        .config_code     (d_cfg),
        .count_limit     (d_limit),
        .table_format    (d_fmt),
        .context_pointer (d_ctx),
        .table_base      (d_ttb),
        .physical_size   (d_ps),
        .format64        (d_aa64),
        .big_endian      (d_endi),
        .affd            (d_affd),
        .granule         (d_gran),
        .inner_cache     (d_ir),
        .outer_cache     (d_or),
        .shareability    (d_sh),
        .vmid            (d_vmid)
    );

    // Enable takes effect in any idle cycle, including one that starts a fetch, so an entry
    // fetched as the enable drops is still applied after the acknowledge reads zero.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            translation_enable_ack <= stream_entry_pkg::ACK_RESET;
        else if (state_reg == stream_entry_pkg::ST_IDLE)
            translation_enable_ack <= translation_enable_bit;                   // [RULE17]
    end

    // Sequencing and entry fetch
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg       <= stream_entry_pkg::ST_IDLE;
            req_ready       <= 1'h0;
            entry_req_valid <= 1'h0;
            entry_req_addr  <= '0;
            addr_reg        <= '0;
            sid_reg         <= '0;
        end
        else
        begin
            entry_req_valid <= 1'h0;
            case (state_reg)
                stream_entry_pkg::ST_IDLE:
                begin
                    req_ready <= 1'h1;
                    if (start_fetch)
                    begin
                        state_reg       <= stream_entry_pkg::ST_FETCH;
                        req_ready       <= 1'h0;
                        entry_req_valid <= 1'h1;                                  // [RULE1]
                        entry_req_addr  <= stream_table_base
                                           + (ADDR_W'(req_stream_id) << stream_entry_pkg::ENTRY_SHIFT); // [RULE2]
                        addr_reg        <= req_addr;
                        sid_reg         <= req_stream_id;
                    end
                end
                stream_entry_pkg::ST_FETCH:
                begin
                    if (entry_rsp_valid)
                    begin
                        state_reg <= stream_entry_pkg::ST_IDLE;
                        req_ready <= 1'h1;
                    end
                end
                default:
                begin
                    state_reg <= stream_entry_pkg::ST_IDLE;
                    req_ready <= 1'h0;
                end
            endcase
        end
    end

    // Decision and walk setup; an entry decision zeroes second-stage fields unless that stage runs, an unacknowledged pass keeps them
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_valid                       <= 1'h0;
            rsp_abort                       <= 1'h0;
            rsp_bypass                      <= 1'h0;
            rsp_entry_used                  <= 1'h0;
            rsp_addr                        <= '0;
            rsp_config                      <= '0;
            stage1_enable                   <= 1'h0;
            stage2_enable                   <= 1'h0;
            descriptor_single               <= 1'h0;
            descriptor_count_limit          <= '0;
            descriptor_table_format         <= '0;
            first_stage_context_pointer     <= '0;
            context_pointer_is_ipa          <= 1'h0;
            second_stage_table_base         <= '0;
            second_stage_physical_size      <= '0;
            second_stage_table_format       <= 1'h0;
            second_stage_endianness         <= 1'h0;
            access_flag_fault_disable       <= 1'h0;
            second_stage_granule            <= '0;
            second_stage_inner_cacheability <= '0;
            second_stage_outer_cacheability <= '0;
            second_stage_shareability       <= '0;
            virtual_machine_identifier      <= '0;
        end
        else if (taken && !translation_enable_ack)
        begin
            // Unacknowledged: no entry is applied, traffic passes untranslated
            rsp_valid      <= 1'h1;                                               // [RULE20]
            rsp_abort      <= 1'h0;
            rsp_bypass     <= 1'h1;
            rsp_entry_used <= 1'h0;
            rsp_addr       <= req_addr;
            rsp_config     <= '0;
            stage1_enable  <= 1'h0;
            stage2_enable  <= 1'h0;
        end
        else if (entry_done)
        begin
            rsp_valid      <= 1'h1;
            rsp_entry_used <= 1'h1;
            rsp_config     <= d_cfg;
            rsp_abort      <= d_abort;                                            // [RULE3] [RULE18] [RULE19]
            rsp_bypass     <= !d_abort && !d_s1 && !d_s2;                         // [RULE4]
            rsp_addr       <= addr_reg;                                           // [RULE4]
            stage1_enable  <= d_s1;                                               // [RULE5] [RULE7]
            stage2_enable  <= d_s2;                                               // [RULE6] [RULE7]
            descriptor_single           <= d_s1 && (d_limit == '0);               // [RULE8]
            descriptor_count_limit      <= d_s1 ? d_limit : '0;
            descriptor_table_format     <= (d_s1 && d_limit != '0) ? d_fmt : '0;  // [RULE9]
            first_stage_context_pointer <= d_s1 ? d_ctx : '0;
            context_pointer_is_ipa      <= d_s1 && d_s2;                          // [RULE10]
            second_stage_table_base         <= d_s2 ? d_ttb : '0;                 // [RULE11]
            second_stage_physical_size      <= d_s2 ? d_ps : '0;                  // [RULE12]
            second_stage_table_format       <= d_s2 && d_aa64;                    // [RULE12]
            second_stage_endianness         <= d_s2 && d_endi;                    // [RULE13]
            access_flag_fault_disable       <= d_s2 && d_affd;                    // [RULE14]
            second_stage_granule            <= d_s2 ? d_gran : '0;
            second_stage_inner_cacheability <= d_s2 ? d_ir : '0;
            second_stage_outer_cacheability <= d_s2 ? d_or : '0;
            second_stage_shareability       <= d_s2 ? d_sh : '0;
            virtual_machine_identifier      <= d_s2 ? d_vmid : '0;                // [RULE15]
        end
        else
            rsp_valid <= 1'h0;
    end

    chk_fetch_per_request: // [RULE1]
    assert property (@(posedge clk) disable iff (!resetn)
        start_fetch |=> entry_req_valid ##1 !entry_req_valid)
    else $error("entry fetch not a single pulse after an accepted request");

    chk_entry_address: // [RULE2]
    assert property (@(posedge clk) disable iff (!resetn)
        entry_req_valid |-> entry_req_addr == $past(stream_table_base)
            + (ADDR_W'(sid_reg) << stream_entry_pkg::ENTRY_SHIFT))
    else $error("entry address is not base plus 64 times the identifier");

    chk_abort_code: // [RULE3]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && rsp_entry_used && rsp_config == stream_entry_pkg::CFG_ABORT
            |-> rsp_abort && !stage1_enable && !stage2_enable)
    else $error("abort code did not abort");

    chk_bypass_addr: // [RULE4]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && rsp_entry_used && !rsp_abort && rsp_config == stream_entry_pkg::CFG_BYPASS
            |-> rsp_bypass && rsp_addr == addr_reg)
    else $error("bypass code did not forward the address");

    chk_stage_select: // [RULE5] [RULE6] [RULE7]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && rsp_entry_used && !rsp_abort
            |-> stage1_enable == rsp_config[0] && stage2_enable == rsp_config[1])
    else $error("stage enables do not match the configuration code");

    chk_single_desc: // [RULE8]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && stage1_enable |-> descriptor_single == (descriptor_count_limit == '0))
    else $error("single descriptor flag disagrees with count limit");

    chk_format_gated: // [RULE9]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && descriptor_count_limit == '0 |-> descriptor_table_format == '0)
    else $error("descriptor table format used with zero count limit");

    chk_pointer_ipa: // [RULE10]
    assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && stage1_enable |-> context_pointer_is_ipa == stage2_enable)
    else $error("context pointer address kind is wrong");

    chk_invalid_entry: // [RULE18] [RULE19]
    assert property (@(posedge clk) disable iff (!resetn)
        entry_done && (!entry_rsp_data[stream_entry_pkg::VALID_BIT] || !d_cfg[2])
            |=> rsp_valid && rsp_abort && !stage1_enable && !stage2_enable)
    else $error("invalid entry was not aborted");

    chk_ack_follows: // [RULE17]
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg == stream_entry_pkg::ST_IDLE |=> translation_enable_ack == $past(translation_enable_bit))
    else $error("acknowledge did not follow the enable while idle");

    chk_no_apply_off: // [RULE20]
    assert property (@(posedge clk) disable iff (!resetn)
        taken && !translation_enable_ack |=> !entry_req_valid && rsp_valid && rsp_bypass && !rsp_entry_used)
    else $error("entry applied while the enable is not acknowledged");

endmodule

/* File: dv/entry_mem_model.sv */
`timescale 1ns/1ps
module entry_mem_model
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Entry fetch
    input  wire logic         entry_req_valid,
    input  wire logic [51:0]  entry_req_addr,
    input  wire logic [51:0]  stream_table_base,
    input  wire logic [1:0]   rsp_delay,
    output logic              entry_rsp_valid,
    output logic [511:0]      entry_rsp_data
);
    logic [511:0] mem [0:15];
    logic [511:0] last_reg;
    logic [3:0]   idx_reg;
    logic [1:0]   wait_reg;
    logic [51:0]  off;
    assign off = entry_req_addr - stream_table_base;
    // Off-cycle data is inverted so a late sample in the design cannot pass by luck
    assign entry_rsp_data = entry_rsp_valid ? last_reg : ~last_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            entry_rsp_valid <= 1'b0;
            last_reg        <= '0;
            idx_reg         <= 4'h0;
            wait_reg        <= 2'h0;
        end
        else
        begin
            entry_rsp_valid <= 1'b0;
            if (entry_req_valid && rsp_delay == 2'h0)
            begin
                entry_rsp_valid <= 1'b1;
                last_reg        <= mem[off[9:6]];
            end
            else if (entry_req_valid)
            begin
                idx_reg  <= off[9:6];
                wait_reg <= rsp_delay;
            end
            else if (wait_reg != 2'h0)
            begin
                wait_reg <= wait_reg - 2'h1;
                entry_rsp_valid <= (wait_reg == 2'h1);
                last_reg <= mem[idx_reg];
            end
        end
    end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int DW = 193;
    logic          clk = 1'b0;
    logic          resetn = 1'b0;
    logic          translation_enable_bit = 1'b0;
    logic          req_valid = 1'b0;
    logic [15:0]   req_stream_id = 16'h0;
    logic [51:0]   req_addr = 52'h0;
    logic [51:0]   stream_table_base = 52'h0000012340000;
    logic [1:0]    rsp_delay = 2'h0;
    logic          translation_enable_ack, req_ready, entry_req_valid, entry_rsp_valid, rsp_valid, rsp_abort;
    logic          rsp_bypass, rsp_entry_used, stage1_enable, stage2_enable, descriptor_single, context_pointer_is_ipa;
    logic          second_stage_table_format, second_stage_endianness, access_flag_fault_disable;
    logic [51:0]   entry_req_addr, rsp_addr;
    logic [511:0]  entry_rsp_data;
    logic [2:0]    rsp_config, second_stage_physical_size;
    logic [4:0]    descriptor_count_limit;
    logic [1:0]    descriptor_table_format, second_stage_granule, second_stage_inner_cacheability;
    logic [1:0]    second_stage_outer_cacheability, second_stage_shareability;
    logic [45:0]   first_stage_context_pointer;
    logic [47:0]   second_stage_table_base;
    logic [15:0]   virtual_machine_identifier;
    logic [DW-1:0] exp_q[$], mask_q[$], got;
    logic [51:0]   addr_q[$];
    logic [132:0]  hold_f = '0;
    int            errors = 0, cmp_count = 0, cycles = 0;
    assign got = {rsp_entry_used, rsp_config, rsp_abort, rsp_bypass, stage1_enable, stage2_enable, rsp_addr,
        virtual_machine_identifier, second_stage_table_base, first_stage_context_pointer, descriptor_count_limit,
        descriptor_single, descriptor_table_format, context_pointer_is_ipa, access_flag_fault_disable,
        second_stage_endianness, second_stage_table_format, second_stage_physical_size, second_stage_shareability,
        second_stage_outer_cacheability, second_stage_inner_cacheability, second_stage_granule};
    stream_entry_decode_enable stream_entry_decode_enable_inst (.*);
    entry_mem_model entry_mem_model_inst (.*);
    always #50 clk = ~clk;
    task automatic cmp_dec(input logic [DW-1:0] g, e, m);
        cmp_count++;
        if ((g & m) !== (e & m))
        begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g & m, e & m);
        end
    endtask
    task automatic cmp_val(input logic [51:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic send(input logic [511:0] e, input logic [15:0] sid, input logic [51:0] a);
        logic ack, ok, ab, s1, s2;
        logic [4:0] lim;
        @(negedge clk);
        while (req_ready !== 1'b1)
            @(negedge clk);
        ack = translation_enable_ack;
        entry_mem_model_inst.mem[sid[3:0]] = e;
        ok = ack && e[0] && e[3];
        s1 = ok && e[1];
        s2 = ok && e[2];
        ab = ack && !ok;
        lim = s1 ? e[63:59] : 5'h0;
        // An unacknowledged pass leaves the walk fields of the last decision standing
        if (ack)
            hold_f = {s2 ? e[143:128] : 16'h0, s2 ? e[243:196] : 48'h0, s1 ? e[51:6] : 46'h0, lim,
                s1 && lim == 5'h0, lim != 5'h0 ? e[5:4] : 2'h0, s1 && s2, s2 ? {e[181:176], e[173:166]} : 14'h0};
        exp_q.push_back({ack, ack ? e[3:1] : 3'h0, ab, !ack || (ok && e[3:1] == 3'h4), s1, s2, a, hold_f});
        mask_q.push_back({DW{1'b1}});
        if (ack)
            addr_q.push_back(stream_table_base + {30'h0, sid, 6'h0});
        req_valid = 1'b1;
        req_stream_id = sid;
        req_addr = a;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        cmp_val(52'(req_ready), 52'(!ack));
    endtask
    always @(negedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            end_sim();
        end
        if (rsp_valid === 1'b1)
            cmp_dec(got, exp_q.pop_front(), mask_q.pop_front());
        if (entry_req_valid === 1'b1)
            cmp_val(entry_req_addr, addr_q.pop_front());
    end
    initial
    begin
        logic [511:0] e;
        void'($urandom(32'h07336ded));
        repeat (5) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 3; i++)
            send({16{$urandom}}, 16'($urandom_range(0, 15)), 52'({$urandom, $urandom}));
        cmp_val(52'(translation_enable_ack), 52'h0);
        translation_enable_bit = 1'b1;
        @(negedge clk);
        cmp_val(52'(translation_enable_ack), 52'h1);
        for (int i = 0; i < 20; i++)
        begin
            e = {16{$urandom}};
            e[3:0] = {i[2:0], 1'(i < 16)};
            if (i[3])
                e[63:59] = 5'h0;
            rsp_delay = 2'($urandom);
            send(e, 16'($urandom_range(0, 15)), 52'({$urandom, $urandom}));
        end
        repeat (8) @(negedge clk);
        translation_enable_bit = 1'b0;
        @(negedge clk);
        cmp_val(52'(translation_enable_ack), 52'h0);
        send({16{$urandom}}, 16'h0005, 52'({$urandom, $urandom}));
        repeat (6) @(negedge clk);
        cmp_val(52'(exp_q.size() + addr_q.size()), 52'h0);
        end_sim();
    end
endmodule
